//--- dv/cpu_bus_model.sv
// Processor-side model of the backplane: control, data, memory cycle
`timescale 1ns/1ns
module cpu_bus_model (
    input  wire logic        clock_i,
    output kbd_pkg::bp_ctl_s bp_ctl_o,
    output logic [7:0]       bp_data_o,
    output logic             mem_cycle_o
);
    initial begin
        bp_ctl_o = {16'h0000, 3'h0, 1'b0, 3'h7};
        bp_data_o = 8'h00;
        mem_cycle_o = 1'b0;
    end

    // Request and its qualifiers change together and hold until idle()
    task automatic drive(input logic [15:0] a, input logic [2:0] bank,
                         input logic io, input logic local_request_n_n,
                         input logic rd_n, input logic s1,
                         input logic [7:0] d);
        @(posedge clock_i);
        bp_ctl_o <= {a, bank, io, local_request_n_n, rd_n, s1};
        bp_data_o <= d;
    endtask

    // Released lines float: address, bank, io and data show the inverse; the three request lines go high
    task automatic idle();
        @(posedge clock_i);
        bp_ctl_o <= {~bp_ctl_o.addr, ~bp_ctl_o.bank, ~bp_ctl_o.io, 3'h7};
        bp_data_o <= ~bp_data_o;
    endtask

    task automatic set_mem(input logic v);
        @(posedge clock_i);
        mem_cycle_o <= v;
    endtask
endmodule

//--- dv/kbd_iface_tb.sv
// Self-checking bench for the keyboard interface block
`timescale 1ns/1ns
module kbd_iface_tb;
    localparam int BEEP = 20;
    localparam int DBNC = 10;
    logic             clock_i = 1'b0;
    logic             rst_i = 1'b1;
    logic [1:0]       reg_addr_i = 2'h0;
    logic [7:0]       reg_wdata_i = 8'h00;
    logic             reg_wr_i = 1'b0;
    logic             reg_rd_i = 1'b0;
    logic [7:0]       reg_rdata_o;
    kbd_pkg::bp_ctl_s bp_ctl;
    logic             mem_cycle;
    logic [7:0]       bp_data;
    logic [7:0]       bp_data_o;
    logic             bp_data_oe_n_o;
    logic             por_n;
    logic             reset_key_i = 1'b0;
    logic             beep_strobe_n_i = 1'b1;
    logic             tone_800hz_i = 1'b0;
    logic [7:0]       kb_data_i = 8'h5a;
    logic [7:0]       kb_data_o;
    logic             kb_data_oe_n_o;
    logic             ind_n;
    logic             mode_n;
    logic             speaker;
    logic             strap = 1'b0;
    logic             ce = 1'b1;
    logic [23:0]      sw = 24'h963ca5;
    int               error_cnt = 0;
    int               num_checks = 0;
    int               cyc = 0;
    int               n;
    logic [7:0]       rd;

    cpu_bus_model u_cpu (
        .clock_i(clock_i), .bp_ctl_o(bp_ctl), .bp_data_o(bp_data),
        .mem_cycle_o(mem_cycle)
    );

    kbd_iface #(.BEEP_CYC(BEEP), .DBNC_CYC(DBNC)) u_dut (
        .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .bp_ctl_i(bp_ctl), .mem_cycle_i(mem_cycle), .bp_data_i(bp_data),
        .bp_data_o(bp_data_o), .bp_data_oe_n_o(bp_data_oe_n_o),
        .power_on_reset_n_o(por_n), .reset_key_i(reset_key_i),
        .beep_strobe_n_i(beep_strobe_n_i), .tone_800hz_i(tone_800hz_i),
        .kb_data_i(kb_data_i), .kb_data_o(kb_data_o),
        .kb_data_oe_n_o(kb_data_oe_n_o), .indicator_enable_n_o(ind_n),
        .mode_select_n_o(mode_n), .speaker_o(speaker),
        .keyboard_disable_strap_i(strap), .switch_open_i(sw)
    );

    always #20 clock_i = ~clock_i;

    // Whole run is well under a thousand cycles
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    // Starts a backplane request and returns once its answer has landed
    task automatic bus(input logic [15:0] a, input logic [2:0] bank,
                       input logic io, input logic local_request_n_n, input logic rd_n,
                       input logic s1, input logic [7:0] d);
        u_cpu.drive(a, bank, io, local_request_n_n, rd_n, s1, d);
        @(posedge clock_i);
        #1;
    endtask

    task automatic probe(input logic [15:0] a, input logic [2:0] bank,
                         input logic io, input logic oe_n,
                         input logic [7:0] d);
        bus(a, bank, io, 1'b1, 1'b0, 1'b1, 8'h00);
        chk1(bp_data_oe_n_o, oe_n);
        if (!oe_n) chk8(bp_data_o, d);
        u_cpu.idle();
    endtask

    task automatic wait_por();
        n = 0;
        while (por_n !== 1'b1 && n < 3 * DBNC) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk1(por_n, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        #1;
        chk1(por_n, 1'b1);
        chk1(ind_n, 1'b1);
        chk1(kb_data_oe_n_o, 1'b1);
        reg_read(2'h0, rd);
        chk8(rd, 8'h01);
        reg_write(2'h3, 8'hff);
        reg_read(2'h3, rd);
        chk8(rd, 8'h00);
        $display("test reset done");

        probe(16'h83a0, 3'h7, 1'b0, 1'b0, sw[23:16]);
        probe(16'h8380, 3'h7, 1'b0, 1'b0, sw[15:8]);
        probe(16'h8320, 3'h7, 1'b0, 1'b0, sw[7:0]);
        probe(16'h8300, 3'h7, 1'b0, 1'b0, kb_data_i);
        probe(16'h82b0, 3'h7, 1'b1, 1'b0, sw[23:16]);
        probe(16'h83a0, 3'h7, 1'b1, 1'b1, 8'h00);
        probe(16'h83a0, 3'h6, 1'b0, 1'b1, 8'h00);
        probe(16'h93a0, 3'h7, 1'b0, 1'b1, 8'h00);
        probe(16'h8ea0, 3'h7, 1'b0, 1'b1, 8'h00);
        @(posedge clock_i);
        strap <= 1'b1;
        probe(16'h83a0, 3'h7, 1'b0, 1'b1, 8'h00);
        @(posedge clock_i);
        strap <= 1'b0;
        $display("test decode done");

        bus(16'h1234, 3'h0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h3c);
        chk1(kb_data_oe_n_o, 1'b0);
        chk8(kb_data_o, 8'hc3);
        chk1(mode_n, 1'b1);
        u_cpu.idle();
        $display("test write done");

        bus(16'h8300, 3'h7, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
        chk1(ind_n, 1'b1);
        u_cpu.idle();
        tone_800hz_i <= 1'b1;
        bus(16'h8300, 3'h7, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
        chk1(ind_n, 1'b0);
        @(posedge clock_i);
        beep_strobe_n_i <= 1'b0;
        n = 0;
        // Strobe held three bursts long must still give one burst;
        // tone toggles each cycle, so half the burst is audible
        repeat (3 * BEEP) begin
            @(posedge clock_i);
            tone_800hz_i <= ~tone_800hz_i;
            #1;
            if (speaker === 1'b1) n++;
        end
        chk8(n[7:0], 8'(BEEP / 2));
        @(posedge clock_i);
        beep_strobe_n_i <= 1'b1;
        u_cpu.idle();
        $display("test beeper done");

        u_cpu.set_mem(1'b1);
        reset_key_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        #1 chk1(por_n, 1'b1);
        u_cpu.set_mem(1'b0);
        repeat (3) @(posedge clock_i);
        #1 chk1(por_n, 1'b0);
        @(posedge clock_i);
        reset_key_i <= 1'b0;
        repeat (DBNC - 1) @(posedge clock_i);
        #1 chk1(por_n, 1'b0);
        wait_por();
        bus(16'h8320, 3'h7, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        chk1(mode_n, 1'b0);
        u_cpu.idle();
        reg_read(2'h1, rd);
        chk8(rd & 8'h01, 8'h00);
        @(posedge clock_i);
        reset_key_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        #1 chk1(por_n, 1'b1);
        @(posedge clock_i);
        reset_key_i <= 1'b0;
        reg_write(2'h0, 8'h01);
        reg_read(2'h1, rd);
        chk8(rd & 8'h01, 8'h01);
        @(posedge clock_i);
        reset_key_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1 chk1(por_n, 1'b0);
        @(posedge clock_i);
        reset_key_i <= 1'b0;
        wait_por();
        // A write while frozen must not touch the enable
        @(posedge clock_i);
        ce <= 1'b0;
        reg_write(2'h0, 8'h00);
        ce <= 1'b1;
        reg_read(2'h1, rd);
        chk8(rd & 8'h01, 8'h01);
        $display("test reset key done");
        results();
    end
endmodule

//--- src/hold_timer.sv
// Reloadable down counter, busy while nonzero
`timescale 1ns/1ns
module hold_timer #(
    parameter int W     = 22,
    parameter int COUNT = 16
) (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic load_i,
    output logic      busy_o
);

    localparam logic [W-1:0] LOAD_VAL = W'(COUNT);
    localparam logic [W-1:0] ONE      = W'(1);

    logic [W-1:0] count;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count <= '0;
        end else if (ce_i) begin
            if (load_i) begin
                count <= LOAD_VAL;
            end else if (count != '0) begin
                count <= count - ONE;
            end
        end
    end

    assign busy_o = (count != '0);

endmodule

//--- src/kbd_iface.sv
// Keyboard interface: reset gating, decode, beeper, switches, buffers
// Notes on behaviour
// - Firmware can disable and re-enable reset key
// - Mode-select write clears reset enable
// - Enabled pressed key pulls power-on line low
// - Enabled key captured on next clock edge
// - Power-on drive deferred during memory cycle
// - Power-on held low for debounce after release
// - Window needs bank 111 and 32K-36K
// - Module selected when bits 11..8 equal 0011
// - Bits 4 and 8 swap during I/O
// - Address bits 7 and 5 pick function
// - Decoder enabled by window, module, request low
// - Function 11 reads switches S through Z
// - Function 00 plus beep strobe triggers beeper
// - Speaker gets 800 Hz tone while beeping
// - One 100 ms burst, then self clear
// - Three switch groups, each on read only
// - Open switch reads one, closed zero
// - Every write drives inverted data to keyboard
// - Addressed read passes keyboard data uninverted
// - Disable strap cuts keyboard section off
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module kbd_iface #(
    parameter int BEEP_CYC = kbd_pkg::BEEP_CYC,
    parameter int DBNC_CYC = kbd_pkg::DBNC_CYC
) (
    input  wire logic           clock_i,
    input  wire logic           rst_i,
    input  wire logic           ce_i,
    // Register port
    input  wire logic [1:0]     reg_addr_i,
    input  wire logic [7:0]     reg_wdata_i,
    input  wire logic           reg_wr_i,
    input  wire logic           reg_rd_i,
    output logic      [7:0]     reg_rdata_o,
    // Backplane
    input  wire kbd_pkg::bp_ctl_s bp_ctl_i,
    input  wire logic           mem_cycle_i,
    input  wire logic [7:0]     bp_data_i,
    output logic      [7:0]     bp_data_o,
    output logic                bp_data_oe_n_o,
    output logic                power_on_reset_n_o,
    // Keyboard side
    input  wire logic           reset_key_i,
    input  wire logic           beep_strobe_n_i,
    input  wire logic           tone_800hz_i,
    input  wire logic [7:0]     kb_data_i,
    output logic      [7:0]     kb_data_o,
    output logic                kb_data_oe_n_o,
    output logic                indicator_enable_n_o,
    output logic                mode_select_n_o,
    output logic                speaker_o,
    // Board straps and switches
    input  wire logic           keyboard_disable_strap_i,
    input  wire logic [23:0]    switch_open_i
);

    ////////////////////////////////////////////////////////////////////
    // Address and function decode

    logic       bit8_eff;
    logic       window_hit;
    logic       module_hit;
    logic [1:0] fn;
    logic       fn_en;
    logic       is_write;
    logic       rd_hit;
    logic       mode_hit;
    logic       sw_read;
    logic [7:0] sw_group;

    // I/O cycles carry bit 8 in the bit 4 position
    assign bit8_eff = bp_ctl_i.io ? bp_ctl_i.addr[4]
                                  : bp_ctl_i.addr[8];

    // Strap blocks every decode, so nothing reaches the keyboard
    assign window_hit = (bp_ctl_i.bank == kbd_pkg::KBD_BANK)
                     && (bp_ctl_i.addr[15:12] == kbd_pkg::WIN_TOP)
                     && !keyboard_disable_strap_i;

    assign module_hit = ({bp_ctl_i.addr[11:9], bit8_eff}
                         == kbd_pkg::MOD_SEL);

    assign fn       = {bp_ctl_i.addr[7], bp_ctl_i.addr[5]};
    assign fn_en    = window_hit && module_hit
                   && !bp_ctl_i.local_request_n_n;
    assign is_write = !bp_ctl_i.status_one;
    assign rd_hit   = window_hit && module_hit
                   && !bp_ctl_i.rd_n;
    assign mode_hit = fn_en && is_write
                   && (fn == kbd_pkg::FN_MODE);
    assign sw_read  = rd_hit && (fn != kbd_pkg::FN_IND);

    // Open switch is a one on the data bus
    always_comb begin
        case (fn)
            kbd_pkg::FN_MODE: begin
                sw_group = switch_open_i[kbd_pkg::SW_AH_LSB +: 8];
            end
            kbd_pkg::FN_JR: begin
                sw_group = switch_open_i[kbd_pkg::SW_JR_LSB +: 8];
            end
            kbd_pkg::FN_SZ: begin
                sw_group = switch_open_i[kbd_pkg::SW_SZ_LSB +: 8];
            end
            default: begin
                sw_group = 8'hff;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Keyboard strobes

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            indicator_enable_n_o <= 1'b1;
            mode_select_n_o      <= 1'b1;
        end else if (ce_i) begin
            indicator_enable_n_o <= !(fn_en
                && (fn == kbd_pkg::FN_IND));
            mode_select_n_o      <= !mode_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reset key gating

    logic                reset_enable;
    logic                reset_ff;
    logic                dbnc_busy;
    kbd_pkg::por_state_e por_state;
    kbd_pkg::por_state_e next_por_state;
    logic                ctrl_wr;

    assign ctrl_wr = reg_wr_i && (reg_addr_i == kbd_pkg::REG_CTRL);

    // A firmware write in the same cycle overrides the strobe clear
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reset_enable <= kbd_pkg::EN_RESET;
        end else if (ce_i) begin
            if (ctrl_wr) begin
                reset_enable <= reg_wdata_i[kbd_pkg::CTRL_EN];
            end else if (mode_hit) begin
                reset_enable <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reset_ff <= 1'b0;
        end else if (ce_i) begin
            reset_ff <= reset_key_i && reset_enable;
        end
    end

    always_comb begin
        next_por_state = por_state;
        case (por_state)
            kbd_pkg::POR_IDLE: begin
                // Never cut into a running memory cycle
                if (reset_ff && !mem_cycle_i) begin
                    next_por_state = kbd_pkg::POR_HELD;
                end
            end
            kbd_pkg::POR_HELD: begin
                if (!reset_ff) begin
                    next_por_state = kbd_pkg::POR_SETTLE;
                end
            end
            kbd_pkg::POR_SETTLE: begin
                // A bounce back restarts the hold
                if (reset_ff) begin
                    next_por_state = kbd_pkg::POR_HELD;
                end else if (!dbnc_busy) begin
                    next_por_state = kbd_pkg::POR_IDLE;
                end
            end
            default: begin
                next_por_state = kbd_pkg::POR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            por_state          <= kbd_pkg::POR_IDLE;
            power_on_reset_n_o <= 1'b1;
        end else if (ce_i) begin
            por_state          <= next_por_state;
            power_on_reset_n_o <= (next_por_state
                                   == kbd_pkg::POR_IDLE);
        end
    end

    // Reloaded while held, runs out after release
    hold_timer #(
        .W     (kbd_pkg::TIMER_W),
        .COUNT (DBNC_CYC)
    ) u_debounce (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .load_i  (por_state == kbd_pkg::POR_HELD),
        .busy_o  (dbnc_busy)
    );

    ////////////////////////////////////////////////////////////////////
    // Beeper

    logic beep_trig;
    logic beep_trig_d;
    logic beeping;

    assign beep_trig = !indicator_enable_n_o
                    && !beep_strobe_n_i;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            beep_trig_d <= 1'b0;
        end else if (ce_i) begin
            beep_trig_d <= beep_trig;
        end
    end

    // Edge start: a long strobe still gives a single burst
    hold_timer #(
        .W     (kbd_pkg::TIMER_W),
        .COUNT (BEEP_CYC)
    ) u_beep (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .load_i  (beep_trig && !beep_trig_d),
        .busy_o  (beeping)
    );

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            speaker_o <= 1'b0;
        end else if (ce_i) begin
            speaker_o <= tone_800hz_i && beeping;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data buffers

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bp_data_o      <= 8'h00;
            bp_data_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            bp_data_oe_n_o <= !rd_hit;
            bp_data_o      <= sw_read ? sw_group
                                      : kb_data_i;
        end
    end

    // Writes to any target reach the keyboard bus; it only
    // listens while one of its strobes is active
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            kb_data_o      <= 8'h00;
            kb_data_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            if (is_write && !keyboard_disable_strap_i) begin
                kb_data_o      <= ~bp_data_i;
                kb_data_oe_n_o <= 1'b0;
            end else if (sw_read) begin
                kb_data_o      <= sw_group;
                kb_data_oe_n_o <= 1'b0;
            end else begin
                kb_data_o      <= 8'h00;
                kb_data_oe_n_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register port

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i) begin
            reg_rdata_o <= 8'h00;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    kbd_pkg::REG_CTRL: begin
                        reg_rdata_o[kbd_pkg::CTRL_EN] <= reset_enable;
                    end
                    kbd_pkg::REG_STATUS: begin
                        reg_rdata_o[kbd_pkg::ST_EN]   <= reset_enable;
                        reg_rdata_o[kbd_pkg::ST_KEY]  <= reset_ff;
                        reg_rdata_o[kbd_pkg::ST_POR]  <=
                            !power_on_reset_n_o;
                        reg_rdata_o[kbd_pkg::ST_BEEP] <= beeping;
                    end
                    default: begin
                        reg_rdata_o <= 8'h00;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    a_enable_clear:
        assert property (ce_i && mode_hit && !ctrl_wr
                         |=> !reset_enable)
        else $error("reset enable not cleared by mode select");

    a_key_capture:
        assert property (ce_i && reset_key_i && reset_enable
                         |=> reset_ff)
        else $error("enabled reset key not captured");

    a_key_blocked:
        assert property (ce_i && !reset_enable
                         |=> !reset_ff)
        else $error("reset key passed while disabled");

    a_por_drive:
        assert property (ce_i && por_state == kbd_pkg::POR_IDLE
                         && reset_ff && !mem_cycle_i
                         |=> !power_on_reset_n_o)
        else $error("power-on line not driven low");

    a_por_defer:
        assert property (ce_i && por_state == kbd_pkg::POR_IDLE
                         && mem_cycle_i
                         |=> power_on_reset_n_o)
        else $error("power-on driven during memory cycle");

    a_por_debounce:
        assert property (ce_i && por_state == kbd_pkg::POR_SETTLE
                         && dbnc_busy
                         |=> !power_on_reset_n_o)
        else $error("power-on released before debounce");

    a_strobe_window:
        assert property (ce_i && fn_en && fn == kbd_pkg::FN_IND
                         |=> !indicator_enable_n_o ##0
                         $past(bp_ctl_i.bank) == kbd_pkg::KBD_BANK)
        else $error("indicator strobe outside window");

    a_speaker_gate:
        assert property (speaker_o |-> $past(beeping))
        else $error("tone reached speaker without burst");

    a_switch_read:
        assert property (ce_i && rd_hit && fn == kbd_pkg::FN_SZ
                         |=> bp_data_o == $past(switch_open_i[23:16])
                         && !bp_data_oe_n_o)
        else $error("switches S-Z not returned");

    a_write_drive:
        assert property (ce_i && is_write && !keyboard_disable_strap_i
                         |=> !kb_data_oe_n_o
                         && kb_data_o == ~$past(bp_data_i))
        else $error("write data not inverted onto keyboard bus");

    a_strap_off:
        assert property (ce_i && keyboard_disable_strap_i
                         |=> bp_data_oe_n_o && mode_select_n_o
                         && indicator_enable_n_o)
        else $error("keyboard section active while strapped off");

endmodule

//--- src/kbd_pkg.sv
// Shared constants and types for the keyboard interface block
package kbd_pkg;

    // Timing
    localparam int CLK_HZ      = 25_000_000;
    localparam int BEEP_MS     = 100;
    localparam int DEBOUNCE_MS = 10;
    localparam int BEEP_CYC    = CLK_HZ / 1000 * BEEP_MS;
    localparam int DBNC_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int TIMER_W     = 22;

    // Address decode
    localparam logic [2:0] KBD_BANK = 3'h7;
    localparam logic [3:0] WIN_TOP  = 4'h8;
    localparam logic [3:0] MOD_SEL  = 4'h3;

    // Function specifier {addr7, addr5}
    localparam logic [1:0] FN_IND  = 2'h0;
    localparam logic [1:0] FN_MODE = 2'h1;
    localparam logic [1:0] FN_JR   = 2'h2;
    localparam logic [1:0] FN_SZ   = 2'h3;

    // Option switch groups
    localparam int SW_AH_LSB = 0;
    localparam int SW_JR_LSB = 8;
    localparam int SW_SZ_LSB = 16;

    // Register port
    localparam logic [1:0] REG_CTRL   = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam int         CTRL_EN    = 0;
    localparam logic       EN_RESET   = 1'b1;
    localparam int         ST_EN      = 0;
    localparam int         ST_KEY     = 1;
    localparam int         ST_POR     = 2;
    localparam int         ST_BEEP    = 3;

    typedef enum logic [1:0] {
        POR_IDLE   = 2'h0,
        POR_HELD   = 2'h1,
        POR_SETTLE = 2'h3
    } por_state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [2:0]  bank;
        logic        io;
        logic        local_request_n_n;
        logic        rd_n;
        logic        status_one;
    } bp_ctl_s;

endpackage
